// ---- verif/crxc_checker.sv ----
// Purpose: Port-level assertions for the receive configuration bank
// Assumes: Config is written only through APB; zero-wait slave
// Notes:   Shadow copies of written fields tie outputs to causes
`timescale 1ns/1ps
module crxc_checker (
    // Clock and reset
    input wire logic                        CLK,
    input wire logic                        SRST,
    // APB
    input wire logic                        PSEL,
    input wire logic                        PENABLE,
    input wire logic                        PWRITE,
    input wire logic [crxc_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0]                 PWDATA,
    input wire logic [31:0]                 PRDATA,
    input wire logic                        PREADY,
    input wire logic                        PSLVERR,
    // Receiver side
    input wire logic                        SOF_DETECT,
    input wire logic                        SUBC_DETECT,
    input wire logic                        TX_DONE,
    input wire logic                        RX_FRAME_END,
    input wire logic [7:0]                  ERROR_VALUE,
    input wire crxc_pkg::crxc_fifo_t        FIFO_PORT,
    input wire logic                        RX_STOP,
    input wire logic                        START_FRAME_IRQ,
    input wire logic                        RX_INPUT_ENABLE,
    input wire logic [2:0]                  RX_RATE,
    input wire logic [3:0]                  DECODER_MIN_LEVEL,
    input wire logic [3:0]                  PHASE_MIN_LEVEL
);
    import crxc_pkg::*;
    logic [7:0] sd_q;  // Shadow start-detect enables
    logic [7:0] ct_q;  // Shadow control
    logic [7:0] gd_q;  // Shadow guard
    logic [7:0] th_q;  // Shadow thresholds
    logic       acc;   // Completed access phase
    logic       unmap; // Address outside the bank
    assign acc   = PSEL && PENABLE && PREADY;
    assign unmap = PADDR[7:2] < IDX_START || PADDR[7:2] > IDX_THRESH;
    // Follow writes as raw write bytes, before the bank drops reserved bits
    always_ff @(posedge CLK) begin
        if (SRST) begin
            sd_q <= RST_START;
            ct_q <= RST_CTRL;
            gd_q <= RST_GUARD;
            th_q <= RST_THRESH;
        end else if (acc && PWRITE) begin
            if (PADDR == {IDX_START, 2'b00}) sd_q <= PWDATA[7:0];
            if (PADDR == {IDX_CTRL, 2'b00}) ct_q <= PWDATA[7:0];
            if (PADDR == {IDX_GUARD, 2'b00}) gd_q <= PWDATA[7:0];
            if (PADDR == {IDX_THRESH, 2'b00}) th_q <= PWDATA[7:0];
        end
    end
    AST_SOF_IRQ: assert property (@(posedge CLK) disable iff (SRST)
        SOF_DETECT && sd_q[SD_SOF_EN] && RX_INPUT_ENABLE |=> START_FRAME_IRQ)
        else $error("start frame irq missing after sof");
    AST_SUBC_IRQ: assert property (@(posedge CLK) disable iff (SRST)
        !$past(SRST) && $rose(SUBC_DETECT) && sd_q[SD_SUB_EN] && RX_INPUT_ENABLE
        |=> START_FRAME_IRQ)
        else $error("start frame irq missing after subcarrier");
    AST_RATE: assert property (@(posedge CLK) disable iff (SRST)
        RX_RATE == ct_q[2:0])
        else $error("rate output differs from field");
    AST_THRESH: assert property (@(posedge CLK) disable iff (SRST)
        DECODER_MIN_LEVEL == th_q[7:4] && PHASE_MIN_LEVEL == th_q[3:0])
        else $error("threshold outputs differ from fields");
    AST_GUARD: assert property (@(posedge CLK) disable iff (SRST)
        TX_DONE && gd_q[6:0] != 7'h00 |=> !RX_INPUT_ENABLE [*8])
        else $error("input not blocked after transmit end");
    AST_UNMAP: assert property (@(posedge CLK) disable iff (SRST)
        acc && unmap |-> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_MULTI: assert property (@(posedge CLK) disable iff (SRST)
        RX_FRAME_END && ct_q[CT_MULTI] && !ct_q[CT_SUPPR] && RX_INPUT_ENABLE
        |=> FIFO_PORT.wr && FIFO_PORT.data == $past(ERROR_VALUE) && !RX_STOP)
        else $error("multi frame end handled wrongly");
    AST_LIVE: assert property (@(posedge CLK) disable iff (SRST)
        acc && !PWRITE && PADDR == {IDX_START, 2'b00}
        |-> PRDATA[SD_SUB_LIVE] == $past(SUBC_DETECT))
        else $error("live bit does not follow detector");
endmodule
bind crxc_top crxc_checker u_crxc_checker (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SOF_DETECT(SOF_DETECT),
    .SUBC_DETECT(SUBC_DETECT), .TX_DONE(TX_DONE), .RX_FRAME_END(RX_FRAME_END),
    .ERROR_VALUE(ERROR_VALUE), .FIFO_PORT(FIFO_PORT), .RX_STOP(RX_STOP),
    .START_FRAME_IRQ(START_FRAME_IRQ), .RX_INPUT_ENABLE(RX_INPUT_ENABLE),
    .RX_RATE(RX_RATE), .DECODER_MIN_LEVEL(DECODER_MIN_LEVEL),
    .PHASE_MIN_LEVEL(PHASE_MIN_LEVEL));

// ---- verif/crxc_rx_src.sv ----
// Purpose: Card-side byte source feeding the decoder stream
// Assumes: One byte strobe every other cycle, frame end apart
// Notes:   Data toggles while no byte is offered
`timescale 1ns/1ps
module crxc_rx_src (
    // Clock
    input wire logic              CLK,
    // Decoder stream
    output crxc_pkg::crxc_byte_t  RX_BYTE,
    output logic                  RX_FRAME_END
);
    import crxc_pkg::*;
    // Idle stream at time zero
    initial begin
        RX_BYTE      = '0;
        RX_FRAME_END = 1'b0;
    end
    // Sends n bytes, byte ep flagged bad, last one partial if pl
    task automatic frame(input int n, input int ep, input logic pl);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK);
            RX_BYTE <= '{1'b1, pl && i == n - 1, i == ep, 8'h30 + i[7:0]};
            @(posedge CLK);
            // Stale data is inverted so nothing reads it by luck
            RX_BYTE <= '{1'b0, 1'b0, 1'b0, ~RX_BYTE.data};
        end
        @(posedge CLK);
        RX_FRAME_END <= 1'b1;
        @(posedge CLK);
        RX_FRAME_END <= 1'b0;
    endtask
endmodule

// ---- verif/test_contactless_rx_config.sv ----
// Purpose: Self-checking bench for the receive configuration bank
// Assumes: Zero-wait APB slave at byte addresses four times the index
// Notes:   Pulse outputs are counted, then compared per scenario
`timescale 1ns/1ps
module test_contactless_rx_config;
    import crxc_pkg::*;
    localparam logic [7:0] A_SD = {IDX_START, 2'b00};
    localparam logic [7:0] A_CT = {IDX_CTRL, 2'b00};
    localparam logic [7:0] A_GD = {IDX_GUARD, 2'b00};
    localparam logic [7:0] A_TH = {IDX_THRESH, 2'b00};
    logic CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic PREADY, PSLVERR, RX_STOP, RX_DONE_IRQ, START_FRAME_IRQ, RX_INPUT_ENABLE;
    logic SOF_DETECT = 0, SUBC_DETECT = 0, TX_DONE = 0, CRC_ENABLE = 0, RX_FRAME_END;
    logic [2:0] TX_RATE_CODE = 3'h4, RX_RATE;
    logic [7:0] ERROR_VALUE = 8'h5A, last_d;
    logic [11:0] RX_BIT_CYCLES;
    logic [3:0] DECODER_MIN_LEVEL, PHASE_MIN_LEVEL;
    crxc_byte_t RX_BYTE;
    crxc_fifo_t FIFO_PORT;
    int errors = 0, n_compared = 0, n_wr, n_fl, n_done, n_stop, n_irq, n_low;
    always #2 CLK = ~CLK;
    crxc_top u_crxc_top (.CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .SOF_DETECT, .SUBC_DETECT, .TX_DONE,
        .TX_RATE_CODE, .RX_BYTE, .RX_FRAME_END, .CRC_ENABLE, .ERROR_VALUE,
        .FIFO_PORT, .RX_STOP, .RX_DONE_IRQ, .START_FRAME_IRQ, .RX_INPUT_ENABLE,
        .RX_RATE, .RX_BIT_CYCLES, .DECODER_MIN_LEVEL, .PHASE_MIN_LEVEL);
    crxc_rx_src u_crxc_rx_src (.CLK, .RX_BYTE, .RX_FRAME_END);
    // Count pulse outputs and cycles with input disabled; a pulse is one cycle so each edge sees it once
    always @(posedge CLK) begin
        if (FIFO_PORT.wr === 1'b1) begin
            n_wr++;
            last_d = FIFO_PORT.data;
        end
        if (FIFO_PORT.flush === 1'b1) n_fl++;
        if (RX_DONE_IRQ === 1'b1) n_done++;
        if (RX_STOP === 1'b1) n_stop++;
        if (START_FRAME_IRQ === 1'b1) n_irq++;
        if (RX_INPUT_ENABLE === 1'b0) n_low++;
    end
    task automatic clr();
        {n_wr, n_fl, n_done, n_stop, n_irq, n_low} = '0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        // Only the watchdog ends a wait on a slave that never answers
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, {24'h000000, x});
    endtask
    task automatic guard(input logic [7:0] v, input int x);
        wr(A_GD, v);
        clr();
        @(posedge CLK) TX_DONE <= 1'b1;
        @(posedge CLK) TX_DONE <= 1'b0;
        repeat (700) @(posedge CLK);
        chk(n_low, x);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard: tests need well under 10000 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        errors++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic e;
        repeat (6) @(posedge CLK);
        SRST <= 1'b0;
        rd(A_SD, RST_START);
        rd(A_CT, RST_CTRL);
        rd(A_GD, RST_GUARD);
        rd(A_TH, RST_THRESH);
        apb(1'b0, 8'hE0, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
        wr(A_SD, 8'h24);
        clr();
        @(posedge CLK) SOF_DETECT <= 1'b1;
        @(posedge CLK) SOF_DETECT <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(n_irq, 1);
        rd(A_SD, 8'h34);
        wr(A_SD, 8'h24);
        rd(A_SD, 8'h24);
        SUBC_DETECT <= 1'b1;
        repeat (3) @(posedge CLK);
        chk(n_irq, 2);
        rd(A_SD, 8'h27);
        SUBC_DETECT <= 1'b0;
        rd(A_SD, 8'h26);
        wr(A_SD, 8'h24);
        rd(A_SD, 8'h24);
        $display("test detect done");
        // Only codes four to seven are ever programmed
        for (int i = 4; i < 8; i++) begin
            wr(A_CT, i[7:0]);
            repeat (2) @(negedge CLK);
            chk({29'h0, RX_RATE}, i);
            chk({20'h0, RX_BIT_CYCLES}, 32'd2358 >> (i - 4));
        end
        wr(A_TH, 8'hA5);
        @(negedge CLK);
        chk({DECODER_MIN_LEVEL, PHASE_MIN_LEVEL}, 8'hA5);
        $display("test settings done");
        guard(8'h02, 2 * 294);
        TX_RATE_CODE <= 3'h7;
        guard(8'h83, 3 * (1179 >> 3));
        guard(8'h00, 0);
        $display("test guard done");
        // Host never reads the FIFO here, so no read lands in the head
        wr(A_CT, 8'h0C);
        clr();
        u_crxc_rx_src.frame(3, 1, 1'b0);
        repeat (3) @(posedge CLK);
        chk(n_fl, 2);
        chk(n_wr, 2);
        chk(n_done, 0);
        clr();
        u_crxc_rx_src.frame(4, 99, 1'b0);
        repeat (3) @(posedge CLK);
        chk(n_wr, 4);
        chk(n_fl, 0);
        chk(n_done, 1);
        chk(n_stop, 1);
        chk(last_d, 8'h33);
        wr(A_CT, 8'h44);
        clr();
        u_crxc_rx_src.frame(3, 99, 1'b0);
        repeat (3) @(posedge CLK);
        chk(n_wr, 4);
        chk(n_stop, 0);
        chk(n_done, 1);
        chk(last_d, ERROR_VALUE);
        $display("test frames done");
        CRC_ENABLE <= 1'b1;
        wr(A_CT, 8'h04);
        clr();
        u_crxc_rx_src.frame(2, 99, 1'b1);
        repeat (3) @(posedge CLK);
        chk(n_wr, 1);
        chk(last_d, 8'h30);
        wr(A_CT, 8'h84);
        clr();
        u_crxc_rx_src.frame(2, 99, 1'b1);
        repeat (3) @(posedge CLK);
        chk(n_wr, 2);
        chk(last_d, 8'h31);
        $display("test partial done");
        close_out();
    end
endmodule

// ---- verilog/crxc_pkg.sv ----
// Purpose: Shared constants and types for the receive configuration bank
// Assumes: 250 MHz system clock, APB register access
// Notes:   Byte address of a register is four times its index
package crxc_pkg;
    // Register indexes and APB address width
    localparam logic [5:0] IDX_START  = 6'h34;
    localparam logic [5:0] IDX_CTRL   = 6'h35;
    localparam logic [5:0] IDX_GUARD  = 6'h36;
    localparam logic [5:0] IDX_THRESH = 6'h37;
    localparam int         ADDR_W     = 8;
    // Start-detect field positions
    localparam int SD_SOF_EN  = 5;
    localparam int SD_SOF_SEEN = 4;
    localparam int SD_SUB_EN  = 2;
    localparam int SD_SUB_SEEN = 1;
    localparam int SD_SUB_LIVE = 0;
    // Control field positions
    localparam int CT_PARTIAL = 7;
    localparam int CT_MULTI   = 6;
    localparam int CT_SUPPR   = 3;
    localparam int CT_RATE_LO = 0;
    // Guard field positions
    localparam int GD_UNIT    = 7;
    // Reset values
    localparam logic [7:0] RST_START  = 8'h00;
    localparam logic [7:0] RST_CTRL   = 8'h04;
    localparam logic [7:0] RST_GUARD  = 8'h00;
    localparam logic [7:0] RST_THRESH = 8'h00;
    // Receive rate codes
    localparam logic [2:0] RATE_106 = 3'h4;
    localparam logic [2:0] RATE_212 = 3'h5;
    localparam logic [2:0] RATE_424 = 3'h6;
    localparam logic [2:0] RATE_847 = 3'h7;
    // Timing: clock period and guard units in picoseconds
    localparam int CLK_PS          = 4000;
    localparam int CARR_UNIT_PS    = 1179941;
    localparam int CARR_UNIT_CYC   = CARR_UNIT_PS / CLK_PS;
    localparam int HALF_BIT106_PS  = 4719764;
    localparam int HALF_BIT106_CYC = HALF_BIT106_PS / CLK_PS;
    localparam int SUPPR_BYTES     = 3;
    // Received byte from the bit decoder
    typedef struct packed {
        logic       valid;
        logic       partial;
        logic       err;
        logic [7:0] data;
    } crxc_byte_t;
    // Write port toward the receive FIFO
    typedef struct packed {
        logic       wr;
        logic       flush;
        logic [7:0] data;
    } crxc_fifo_t;
    // Guard timer states
    typedef enum logic [0:0] {
        GRD_IDLE = 1'b0,
        GRD_RUN  = 1'b1
    } crxc_grd_t;
endpackage

// ---- verilog/crxc_top.sv ----
// Purpose: Receive path configuration and status bank with guard and EMD logic
// Assumes: All inputs come from logic on CLK; one receiver frame at a time
// Notes:   Zero-wait APB slave; unmapped addresses answer PSLVERR
//          Read data is taken in the setup phase, so the live bit shows
//          its level one cycle before the access edge
//          Guard units are cycle counts rounded down to whole clocks
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module crxc_top #(
    parameter int BITCYC_W = 12
) (
    // Clock and reset
    input  wire  logic                          CLK,
    input  wire  logic                          SRST,
    // APB slave
    input  wire  logic                          PSEL,
    input  wire  logic                          PENABLE,
    input  wire  logic                          PWRITE,
    input  wire  logic [crxc_pkg::ADDR_W-1:0]   PADDR,
    input  wire  logic [31:0]                   PWDATA,
    output logic [31:0]                         PRDATA,
    output logic                                PREADY,
    output logic                                PSLVERR,
    // Detectors and transmitter status
    input  wire  logic                          SOF_DETECT,
    input  wire  logic                          SUBC_DETECT,
    input  wire  logic                          TX_DONE,
    input  wire  logic [2:0]                    TX_RATE_CODE,
    // Decoder byte stream
    input  wire  crxc_pkg::crxc_byte_t          RX_BYTE,
    input  wire  logic                          RX_FRAME_END,
    input  wire  logic                          CRC_ENABLE,
    input  wire  logic [7:0]                    ERROR_VALUE,
    // FIFO and receiver control
    output crxc_pkg::crxc_fifo_t                FIFO_PORT,
    output logic                                RX_STOP,
    output logic                                RX_DONE_IRQ,
    output logic                                START_FRAME_IRQ,
    output logic                                RX_INPUT_ENABLE,
    // Decoder settings
    output logic [2:0]                          RX_RATE,
    output logic [BITCYC_W-1:0]                 RX_BIT_CYCLES,
    output logic [3:0]                          DECODER_MIN_LEVEL,
    output logic [3:0]                          PHASE_MIN_LEVEL
);
    import crxc_pkg::*;

    // Elaboration check: bit period at the slowest rate must fit
    // A narrower counter would wrap and shorten the slowest bit period
    if (2 * HALF_BIT106_CYC >= (1 << BITCYC_W)) begin : g_chk
        $error("BITCYC_W too small for slowest bit period");
    end

    localparam logic [7:0] A_START  = {IDX_START, 2'b00};  // Byte addresses
    localparam logic [7:0] A_CTRL   = {IDX_CTRL, 2'b00};
    localparam logic [7:0] A_GUARD  = {IDX_GUARD, 2'b00};
    localparam logic [7:0] A_THRESH = {IDX_THRESH, 2'b00};
    // Counts are cut to the timer width on purpose; the package
    // values are known to fit in twelve bits
    localparam logic [11:0] CARR_CYC = 12'(CARR_UNIT_CYC);
    localparam logic [11:0] HALF_CYC = 12'(HALF_BIT106_CYC);
    localparam logic [1:0]  SUPPR_N  = 2'(SUPPR_BYTES);

    // Software-visible registers
    logic [7:0]  start_q;        // Enables and sticky flags
    logic [7:0]  ctrl_q;         // Receive control
    logic [7:0]  guard_q;        // Guard unit and value
    logic [7:0]  thresh_q;       // Decoder thresholds
    // Edge memory and bus helpers
    logic        subc_q;         // Previous subcarrier level, for rise detect
    logic        wr_en;          // APB write in access phase
    logic        hit;            // Address decodes to a register
    logic [7:0]  rd_d;           // Read mux
    // Guard timer
    crxc_grd_t   grd_q;          // Guard timer state
    logic [11:0] div_q;          // Cycles within one guard unit
    logic [6:0]  units_q;        // Guard units elapsed
    logic [11:0] unit_cyc;       // Cycles per guard unit
    logic [11:0] half_cyc;       // Half bit period at transmit rate
    // Receiver inputs behind the guard gate
    logic        accept;         // Receiver input taken
    logic        sof_ev;         // Gated SOF event
    logic        subc_lv;        // Gated subcarrier level
    logic        byte_v;         // Gated byte strobe
    logic        end_v;          // Gated frame end
    // Suppression bookkeeping
    logic [1:0]  cnt_q;          // Bytes stored this frame, saturating
    logic        early;          // Still within the suppressed head

    // Writes land in the access phase
    assign wr_en  = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;        // Zero wait states keeps the master simple

    // Address decode
    always_comb begin
        // Defaults keep the mux free of latches
        hit  = 1'b1;
        rd_d = 8'h00;
        if (PADDR == A_START) begin
            // Live bit comes straight from the detector
            rd_d = {2'b00, start_q[5:4], 1'b0, start_q[2:1], SUBC_DETECT};
        end else if (PADDR == A_CTRL) begin
            // Reserved bits read as zero
            rd_d = {ctrl_q[7:6], 2'b00, ctrl_q[3:0]};
        end else if (PADDR == A_GUARD) begin
            rd_d = guard_q;
        end else if (PADDR == A_THRESH) begin
            rd_d = thresh_q;
        end else begin
            hit = 1'b0;          // Unmapped reads as zero
        end
    end

    // Read data captured in setup phase, held through access
    // One cycle early costs a flop but keeps PRDATA glitch free
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            // Error flag uses the same decode as the data
            PRDATA  <= {24'h000000, rd_d};
            PSLVERR <= !hit;
        end
    end

    // Input gating: everything from the receiver is dropped in guard time
    // The live bit in the read mux stays ungated so software can
    // still watch the detector while the guard runs
    assign accept  = (grd_q == GRD_IDLE);
    assign sof_ev  = SOF_DETECT && accept;
    assign subc_lv = SUBC_DETECT && accept;
    assign byte_v  = RX_BYTE.valid && accept;
    assign end_v   = RX_FRAME_END && accept;

    // Start-detect register: enables from software, flags set wins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            // Flags and enables start clear
            start_q <= RST_START;
        end else begin
            if (wr_en && PADDR == A_START) begin
                // Enable bits follow the write data
                start_q[SD_SOF_EN] <= PWDATA[SD_SOF_EN];
                start_q[SD_SUB_EN] <= PWDATA[SD_SUB_EN];
                // Zero clears, one leaves the flag alone
                if (!PWDATA[SD_SOF_SEEN]) begin
                    start_q[SD_SOF_SEEN] <= 1'b0;
                end
                if (!PWDATA[SD_SUB_SEEN]) begin
                    start_q[SD_SUB_SEEN] <= 1'b0;
                end
            end
            // Placed after the clear so a same-cycle event survives
            // Later assignment wins: set has priority over clear
            if (sof_ev) begin
                start_q[SD_SOF_SEEN] <= 1'b1;
            end
            if (subc_lv) begin
                start_q[SD_SUB_SEEN] <= 1'b1;
            end
        end
    end

    // Start-frame interrupt: one pulse per SOF or subcarrier arrival
    // Subcarrier is a level, so only its rise may interrupt; a
    // steady carrier would otherwise hold the request high
    always_ff @(posedge CLK) begin
        if (SRST) begin
            subc_q          <= 1'b0;
            START_FRAME_IRQ <= 1'b0;
        end else begin
            // Gated level: a carrier present at guard end counts as a rise
            subc_q          <= subc_lv;
            START_FRAME_IRQ <= (sof_ev && start_q[SD_SOF_EN])
                             || (subc_lv && !subc_q && start_q[SD_SUB_EN]);
        end
    end

    // Configuration registers written by software
    always_ff @(posedge CLK) begin
        if (SRST) begin
            // Control resets to the slowest receive rate
            ctrl_q   <= RST_CTRL;
            guard_q  <= RST_GUARD;
            thresh_q <= RST_THRESH;
        end else if (wr_en) begin
            if (PADDR == A_CTRL) begin
                // Reserved control bits are never stored
                ctrl_q <= {PWDATA[7:6], 2'b00, PWDATA[3:0]};
            end else if (PADDR == A_GUARD) begin
                guard_q <= PWDATA[7:0];
            end else if (PADDR == A_THRESH) begin
                thresh_q <= PWDATA[7:0];
            end
        end
    end

    // Decoder settings driven straight from the registers
    // The decoder sees a change the cycle after the write
    assign DECODER_MIN_LEVEL = thresh_q[7:4];
    assign PHASE_MIN_LEVEL   = thresh_q[3:0];
    assign RX_RATE           = ctrl_q[CT_RATE_LO +: 3];

    // Bit period per rate; reserved codes fall back to the slowest rate
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RX_BIT_CYCLES <= '0;
        end else begin
            // Registered so the decoder never sees a half-updated count
            case (ctrl_q[CT_RATE_LO +: 3])
                RATE_212: RX_BIT_CYCLES <= BITCYC_W'(HALF_CYC);
                RATE_424: RX_BIT_CYCLES <= BITCYC_W'(HALF_CYC >> 1);
                RATE_847: RX_BIT_CYCLES <= BITCYC_W'(HALF_CYC >> 2);
                // Codes below four are reserved; use the slowest rate
                default:  RX_BIT_CYCLES <= BITCYC_W'({HALF_CYC, 1'b0} >> 0);
            endcase
        end
    end

    // Half bit at the transmitter's own rate sets the slow guard unit
    always_comb begin
        case (TX_RATE_CODE)
            RATE_212: half_cyc = HALF_CYC >> 1;
            RATE_424: half_cyc = HALF_CYC >> 2;
            RATE_847: half_cyc = HALF_CYC >> 3;
            default:  half_cyc = HALF_CYC;
        endcase
        // Fast unit is a fixed carrier multiple, slow unit the half bit
        unit_cyc = guard_q[GD_UNIT] ? half_cyc : CARR_CYC;
    end

    // Guard timer: counts whole units after each transmission
    always_ff @(posedge CLK) begin
        if (SRST) begin
            grd_q   <= GRD_IDLE;
            div_q   <= 12'h000;
            units_q <= 7'h00;
        end else begin
            case (grd_q)
                // Idle: counters parked, waiting for a transmit end
                GRD_IDLE: begin
                    div_q   <= 12'h000;
                    units_q <= 7'h00;
                    // A zero value leaves input open at once
                    if (TX_DONE && guard_q[6:0] != 7'h00) begin
                        grd_q <= GRD_RUN;
                    end
                end
                // Run: each wrap of the divider is one guard unit; a
                // transmit end seen here is ignored, the guard does
                // not restart
                GRD_RUN: begin
                    if (div_q >= unit_cyc - 12'h001) begin
                        div_q   <= 12'h000;
                        units_q <= units_q + 7'h01;
                        if (units_q + 7'h01 >= guard_q[6:0]) begin
                            grd_q <= GRD_IDLE;
                        end
                    end else begin
                        div_q <= div_q + 12'h001;
                    end
                end
                // Only an unknown (X) state lands here; it recovers to idle
                default: grd_q <= GRD_IDLE;
            endcase
        end
    end

    // Tells the receiver that its input is being ignored
    assign RX_INPUT_ENABLE = accept;

    // Head of frame is still inside the suppression window
    // Count saturates at three, all the window needs
    assign early = ctrl_q[CT_SUPPR] && (cnt_q < SUPPR_N);

    // FIFO writes, suppression and end-of-stream handling
    always_ff @(posedge CLK) begin
        if (SRST) begin
            FIFO_PORT   <= '0;
            RX_STOP     <= 1'b0;
            RX_DONE_IRQ <= 1'b0;
            cnt_q       <= 2'b00;
        end else begin
            // Pulses default low every cycle
            FIFO_PORT   <= '0;
            RX_STOP     <= 1'b0;
            RX_DONE_IRQ <= 1'b0;
            // Frame end and byte strobe never meet; end wins anyway
            if (end_v) begin
                cnt_q <= 2'b00;
                if (early) begin
                    // Too short to be a real answer: treat as noise
                    FIFO_PORT.flush <= 1'b1;
                end else begin
                    // Long enough to be a real answer
                    RX_DONE_IRQ <= 1'b1;
                    if (ctrl_q[CT_MULTI]) begin
                        FIFO_PORT.wr   <= 1'b1;
                        FIFO_PORT.data <= ERROR_VALUE;
                    end else begin
                        RX_STOP <= 1'b1;
                    end
                end
            end else if (byte_v) begin
                if (early && RX_BYTE.err) begin
                    // Collisions arrive as errors too; receiver keeps going
                    FIFO_PORT.flush <= 1'b1;
                    cnt_q           <= 2'b00;
                end else if (!(RX_BYTE.partial && CRC_ENABLE && !ctrl_q[CT_PARTIAL])) begin
                    // Partial bytes pass unless the CRC check would drop them
                    FIFO_PORT.wr   <= 1'b1;
                    FIFO_PORT.data <= RX_BYTE.data;
                    // Stop counting once past the window
                    if (cnt_q != 2'b11) begin
                        cnt_q <= cnt_q + 2'b01;
                    end
                end
            end
        end
    end

endmodule
